// *** clock_dist_cfg.svh ***
// constants for the clock source and distribution unit
`ifndef CLOCK_DIST_CFG_SVH
`define CLOCK_DIST_CFG_SVH

// fuse encodings, a fuse reads 0 when programmed
`define FUSE_PROGRAMMED 1'b0
`define SRC_CODE_RC 4'h2
`define SRC_CODE_EXT 4'h0
`define SRC_CODE_LF_TOP 2'h1
`define SRC_CODE_XTAL_BIT 3

// reset time-out lengths in watchdog oscillator cycles
`define WD_NONE_TICKS 17'h00000
`define WD_SHORT_TICKS 17'h01000
`define WD_LONG_TICKS 17'h10000

// oscillator start-up lengths in source cycles
`define SU_258_TICKS 17'h00102
`define SU_1K_TICKS 17'h00400
`define SU_16K_TICKS 17'h04000
`define SU_32K_TICKS 17'h08000
`define SU_FAST_TICKS 17'h00006

// system prescaler
`define DIV8_LAST 3'h7
`define DIV_RESET 3'h0
`define TRIM_RESET 8'h00

`endif

// *** clock_dist_pkg.sv ***
// types shared by the clock source and distribution unit
package clock_dist_pkg;

   typedef enum logic [2:0] {
      SLP_IDLE,
      SLP_CONV_NOISE_RED,
      SLP_POWER_DOWN,
      SLP_POWER_SAVE,
      SLP_STANDBY
   } sleep_mode_t;

   typedef enum logic [1:0] {
      ST_OSC_START,
      ST_RST_TIMEOUT,
      ST_RUN,
      ST_SLEEP
   } clk_state_t;

   typedef enum logic [1:0] {
      RTO_NONE,
      RTO_SHORT,
      RTO_LONG
   } rst_timeout_t;

   typedef struct packed {
      logic xtal;
      logic low_freq;
      logic rc;
      logic ext;
   } src_sel_t;

   typedef struct packed {
      logic core;
      logic program_memory;
      logic peripheral;
      logic converter;
   } domain_en_t;

endpackage

// *** clk_gate_glitchfree.sv ***
// glitch-free clock gate, enable retimed on the low phase
module clk_gate_glitchfree (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // control
   input wire logic i_en,
   // gated clock
   output logic o_clk
);

   logic en_r;

   // enable only changes while the clock is low, so no runt pulse
   always_ff @(negedge i_clk) begin
      if (!i_rst_n) begin
         en_r <= 1'b0;
      end else begin
         en_r <= i_en;
      end
   end

   assign o_clk = i_clk & en_r;

endmodule // clk_gate_glitchfree

// *** clock_source_and_distribution.sv ***
// clock source selection, start-up timing and gated clock distribution
// Function
// - halted core clock stops all core work
// - sleep mode gates off unused clock domains
// - async interrupt detect while peripheral clock stopped
// - serial start detect goes async while peripheral clock stopped
// - program memory clock follows core clock
// - async timer clock runs through sleep except power-down
// - display shares async timer clock domain
// - converter clock runs in idle and noise-reduction sleep
// - codes 1xxx crystal, 01xx low-frequency crystal
// - 0010 RC, 0000 external, 0011/0001 reserved
// - fuse bit 0 programmed, 1 unprogrammed
// - deep-sleep wake waits source start-up count
// - reset adds delay counted on watchdog ticks
// - reset time-out none, 4096 or 65536 watchdog ticks
// - default RC code, start-up 10, divide-by-eight
// - default prescaler divides source by eight
// - programmed divide fuse divides at start-up
// - reset loads calibration byte into trim
`include "clock_dist_cfg.svh"

module clock_source_and_distribution
   import clock_dist_pkg::*;
#(
   parameter logic [16:0] WD_LONG_TICKS = `WD_LONG_TICKS,
   parameter logic [16:0] SU_16K_TICKS = `SU_16K_TICKS,
   parameter logic [16:0] SU_32K_TICKS = `SU_32K_TICKS
) (
   // clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_RST_N,
   // fuses
   input wire logic [3:0] I_CLOCK_SOURCE_SELECT_FUSES,
   input wire logic [1:0] I_STARTUP_TIME_FUSES,
   input wire logic I_DIVIDE_BY_EIGHT_FUSE,
   // oscillator side
   input wire logic I_WATCHDOG_OSC_TICK,
   input wire logic I_SRC_OSC_TICK,
   input wire logic I_ASYNC_SRC_LEVEL,
   input wire logic [7:0] I_CAL_BYTE,
   // sleep control
   input wire logic I_SLEEP_REQ,
   input wire sleep_mode_t I_SLEEP_MODE,
   input wire logic I_WAKE,
   // distributed clocks
   output logic O_CORE_CLOCK,
   output logic O_PROGRAM_MEMORY_CLOCK,
   output logic O_PERIPHERAL_CLOCK,
   output logic O_CONVERTER_CLOCK,
   output logic O_ASYNC_TIMER_CLOCK,
   // status
   output src_sel_t O_SRC_ENABLE,
   output logic O_CFG_INVALID,
   output logic O_CORE_HALTED,
   output logic O_INSTR_EN,
   output logic O_ASYNC_INT_DETECT,
   output logic O_SERIAL_START_ASYNC,
   output logic O_DIV8_ACTIVE,
   output logic [7:0] O_OSC_TRIM
);

   clk_state_t state_r;
   clk_state_t state_nxt;
   sleep_mode_t mode_r;
   rst_timeout_t rto_sel;
   logic [16:0] cnt_r;
   logic [16:0] cnt_nxt;
   logic from_reset_r;
   logic [2:0] div_r;
   logic div8_r;
   logic [7:0] trim_r;
   logic async_clk_r;
   logic async_det_r;
   src_sel_t src_r;
   logic invalid_r;

   // fuse decode
   wire [3:0] src_code = I_CLOCK_SOURCE_SELECT_FUSES;
   wire [1:0] su_code = I_STARTUP_TIME_FUSES;
   wire div8_prog = (I_DIVIDE_BY_EIGHT_FUSE == `FUSE_PROGRAMMED);
   src_sel_t src_dec;
   assign src_dec.xtal = src_code[`SRC_CODE_XTAL_BIT];
   assign src_dec.low_freq = (src_code[3:2] == `SRC_CODE_LF_TOP);
   assign src_dec.rc = (src_code == `SRC_CODE_RC);
   assign src_dec.ext = (src_code == `SRC_CODE_EXT);
   // reserved codes light no source at all
   wire cfg_invalid = ~|src_dec;

   // reset time-out choice; crystal mixes in the low select bit
   always_comb begin
      rto_sel = RTO_LONG;
      if (src_dec.xtal) begin
         unique case ({src_code[0], su_code})
            3'h0, 3'h3, 3'h6: rto_sel = RTO_SHORT;
            3'h2, 3'h5: rto_sel = RTO_NONE;
            default: rto_sel = RTO_LONG;
         endcase
      end else begin
         unique case (su_code)
            2'h0: rto_sel = RTO_NONE;
            2'h1: rto_sel = RTO_SHORT;
            default: rto_sel = RTO_LONG; // reserved code takes the safe length
         endcase
      end
   end

   wire [16:0] rst_ticks = (rto_sel == RTO_SHORT) ? `WD_SHORT_TICKS :
                           (rto_sel == RTO_LONG) ? WD_LONG_TICKS : `WD_NONE_TICKS;

   // oscillator start-up length per source
   wire [16:0] xtal_ticks = (!src_code[0] && !su_code[1]) ? `SU_258_TICKS :
                            (!src_code[0] || su_code == 2'h0) ? `SU_1K_TICKS : SU_16K_TICKS;
   wire [16:0] lf_ticks = src_code[0] ? SU_32K_TICKS : `SU_1K_TICKS;
   wire [16:0] su_ticks = src_dec.xtal ? xtal_ticks :
                          src_dec.low_freq ? lf_ticks : `SU_FAST_TICKS;

   // sequencing
   wire run = (state_r == ST_RUN);
   wire sleeping = (state_r == ST_SLEEP);
   wire deep_mode = (mode_r == SLP_POWER_DOWN) || (mode_r == SLP_POWER_SAVE);
   // a reserved source never ticks the start-up counter
   wire su_tick = I_SRC_OSC_TICK & ~cfg_invalid;
   wire su_done = su_tick && (cnt_r >= su_ticks - 17'h00001);
   wire rto_done = (rst_ticks == `WD_NONE_TICKS) ||
                   (I_WATCHDOG_OSC_TICK && (cnt_r >= rst_ticks - 17'h00001));

   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      unique case (state_r)
         ST_OSC_START: begin
            cnt_nxt = su_tick ? cnt_r + 17'h00001 : cnt_r;
            if (su_done) begin
               cnt_nxt = 17'h00000;
               state_nxt = from_reset_r ? ST_RST_TIMEOUT : ST_RUN;
            end
         end
         ST_RST_TIMEOUT: begin
            // counted on watchdog ticks, not on the system clock
            cnt_nxt = I_WATCHDOG_OSC_TICK ? cnt_r + 17'h00001 : cnt_r;
            if (rto_done) begin
               cnt_nxt = 17'h00000;
               state_nxt = ST_RUN;
            end
         end
         ST_RUN: begin
            if (I_SLEEP_REQ) begin
               state_nxt = ST_SLEEP;
            end
         end
         ST_SLEEP: begin
            if (I_WAKE) begin
               cnt_nxt = 17'h00000;
               state_nxt = deep_mode ? ST_OSC_START : ST_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         state_r <= ST_OSC_START;
         cnt_r <= 17'h00000;
         from_reset_r <= 1'b1;
         mode_r <= SLP_IDLE;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         if (state_nxt == ST_RUN) begin
            from_reset_r <= 1'b0;
         end
         if (run && I_SLEEP_REQ) begin
            mode_r <= I_SLEEP_MODE;
         end
      end
   end

   // domain enables per sleep mode
   domain_en_t dom_en;
   assign dom_en.core = run;
   assign dom_en.program_memory = dom_en.core;
   assign dom_en.peripheral = run | (sleeping && mode_r == SLP_IDLE);
   assign dom_en.converter = run | (sleeping && (mode_r == SLP_IDLE ||
                                                 mode_r == SLP_CONV_NOISE_RED));
   // async domain stays up in every sleep mode except full power-down
   wire async_en = ~cfg_invalid & ~(sleeping && mode_r == SLP_POWER_DOWN);

   // prescaler; div8 latched once at reset so a fuse glitch cannot retime
   wire tick_en = ~div8_r | (div_r == `DIV8_LAST);

   always_ff @(posedge I_REF_CLK) begin
      if (!I_RST_N) begin
         div_r <= `DIV_RESET;
         div8_r <= div8_prog;
         trim_r <= I_CAL_BYTE;
         async_clk_r <= 1'b0;
         async_det_r <= 1'b1;
         src_r <= '0;
         invalid_r <= 1'b0;
      end else begin
         div_r <= div_r + 3'h1;
         async_clk_r <= I_ASYNC_SRC_LEVEL & async_en;
         async_det_r <= ~dom_en.peripheral;
         src_r <= src_dec;
         invalid_r <= cfg_invalid;
      end
   end

   // gated clocks; one gate per ref-derived domain
   wire [3:0] gate_en = dom_en & {4{tick_en}};
   wire [3:0] gate_clk;
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_gate
         clk_gate_glitchfree clk_gate_glitchfree_inst (
            .i_clk(I_REF_CLK),
            .i_rst_n(I_RST_N),
            .i_en(gate_en[g]),
            .o_clk(gate_clk[g])
         );
      end
   endgenerate

   assign O_CORE_CLOCK = gate_clk[3];
   assign O_PROGRAM_MEMORY_CLOCK = gate_clk[2];
   assign O_PERIPHERAL_CLOCK = gate_clk[1];
   assign O_CONVERTER_CLOCK = gate_clk[0];
   // display controller and async counter share this one
   assign O_ASYNC_TIMER_CLOCK = async_clk_r;
   assign O_SRC_ENABLE = src_r;
   assign O_CFG_INVALID = invalid_r;
   assign O_CORE_HALTED = ~dom_en.core;
   assign O_INSTR_EN = dom_en.core;
   assign O_ASYNC_INT_DETECT = async_det_r;
   assign O_SERIAL_START_ASYNC = async_det_r;
   assign O_DIV8_ACTIVE = div8_r;
   assign O_OSC_TRIM = trim_r;

   a_core_halt_exec: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      O_CORE_HALTED |-> !O_INSTR_EN && !gate_en[3])
      else $error("core executes while halted");

   a_sleep_gates_core: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (sleeping && mode_r != SLP_IDLE) |-> !gate_en[3] && !gate_en[1])
      else $error("clock left running in sleep");

   a_async_int_detect: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (sleeping && mode_r == SLP_POWER_DOWN) |=> O_ASYNC_INT_DETECT)
      else $error("async interrupt detect off with peripheral clock halted");

   a_serial_async: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      $rose(run) |=> !O_SERIAL_START_ASYNC)
      else $error("serial start detect stays async while running");

   a_flash_follows: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      gate_en[2] == gate_en[3])
      else $error("program memory clock diverges from core clock");

   a_async_in_save: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (sleeping && mode_r == SLP_POWER_SAVE && !cfg_invalid && I_ASYNC_SRC_LEVEL)
      |=> O_ASYNC_TIMER_CLOCK)
      else $error("async timer clock stopped in power-save");

   a_conv_noise_red: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (sleeping && mode_r == SLP_CONV_NOISE_RED) |-> dom_en.converter && !dom_en.peripheral)
      else $error("converter domain wrong in noise reduction");

   a_xtal_decode: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      I_CLOCK_SOURCE_SELECT_FUSES[3] |=> O_SRC_ENABLE == 4'h8)
      else $error("crystal code not decoded");

   a_reserved_code: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_CLOCK_SOURCE_SELECT_FUSES == 4'h3 || I_CLOCK_SOURCE_SELECT_FUSES == 4'h1)
      |=> O_CFG_INVALID && O_SRC_ENABLE == 4'h0)
      else $error("reserved code enabled a source");

   a_wake_startup: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (sleeping && I_WAKE && deep_mode) |=> state_r == ST_OSC_START && !O_INSTR_EN)
      else $error("deep wake skipped start-up");

   a_rst_timeout_len: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (state_r == ST_RST_TIMEOUT && state_nxt == ST_RUN && rst_ticks != 17'h00000)
      |-> I_WATCHDOG_OSC_TICK && cnt_r == rst_ticks - 17'h00001)
      else $error("reset time-out ended at wrong count");

   a_div8_period: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (div8_r && tick_en) |=> !tick_en [*7] ##1 tick_en)
      else $error("prescaler not dividing by eight");

   a_trim_load: assert property (@(posedge I_REF_CLK)
      $rose(I_RST_N) |-> O_OSC_TRIM == $past(I_CAL_BYTE))
      else $error("trim not loaded during reset");

   a_idle_domains: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (sleeping && mode_r == SLP_IDLE) |-> dom_en.peripheral && dom_en.converter && !dom_en.core)
      else $error("idle sleep domain enables wrong");

   a_det_in_run: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      run |=> !O_ASYNC_INT_DETECT)
      else $error("async interrupt detect active while running");

   a_serial_sleep: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (sleeping && mode_r != SLP_IDLE) |=> O_SERIAL_START_ASYNC)
      else $error("serial start detect not async in sleep");

   a_async_off_pd: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (sleeping && mode_r == SLP_POWER_DOWN) |=> !O_ASYNC_TIMER_CLOCK)
      else $error("async timer clock running in power-down");

   a_async_follows: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (run && !cfg_invalid) |=> O_ASYNC_TIMER_CLOCK == $past(I_ASYNC_SRC_LEVEL))
      else $error("async timer clock does not follow its source");

   a_lf_decode: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_CLOCK_SOURCE_SELECT_FUSES[3:2] == 2'h1) |=> O_SRC_ENABLE == 4'h4)
      else $error("low-frequency code not decoded");

   a_rc_decode: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_CLOCK_SOURCE_SELECT_FUSES == 4'h2) |=> O_SRC_ENABLE == 4'h2)
      else $error("rc code not decoded");

   a_ext_decode: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (I_CLOCK_SOURCE_SELECT_FUSES == 4'h0) |=> O_SRC_ENABLE == 4'h1)
      else $error("external clock code not decoded");

   a_div8_fuse: assert property (@(posedge I_REF_CLK)
      !I_RST_N |=> O_DIV8_ACTIVE == !$past(I_DIVIDE_BY_EIGHT_FUSE))
      else $error("divide fuse polarity wrong");

   a_startup_wait: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (state_r == ST_OSC_START && !I_SRC_OSC_TICK) |=> state_r == ST_OSC_START)
      else $error("start-up advanced without a source tick");

   a_timeout_wd: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (state_r == ST_RST_TIMEOUT && !I_WATCHDOG_OSC_TICK && rst_ticks != `WD_NONE_TICKS)
      |=> state_r == ST_RST_TIMEOUT)
      else $error("reset time-out advanced without a watchdog tick");

   a_reset_to_timeout: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (state_r == ST_OSC_START && su_done && from_reset_r) |=> state_r == ST_RST_TIMEOUT)
      else $error("reset start-up skipped the time-out");

   a_invalid_stuck: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      (state_r == ST_OSC_START && cfg_invalid) |=> state_r == ST_OSC_START)
      else $error("reserved code finished start-up");

   a_trim_hold: assert property (@(posedge I_REF_CLK) disable iff (!I_RST_N)
      I_RST_N |=> $stable(O_OSC_TRIM))
      else $error("trim changed outside reset");

endmodule // clock_source_and_distribution

// *** clock_source_and_distribution_bench.sv ***
// self-checking bench for the clock source and distribution unit
module clock_source_and_distribution_bench import clock_dist_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, dv, wdo, srct, asy, sreq, wake;
   logic [3:0] cks;
   logic [1:0] suf;
   logic [7:0] cal;
   sleep_mode_t smode;
   logic core_c, pm_c, per_c, conv_c, asy_c, inv, halted, instr, det, ser, div8;
   src_sel_t src;
   logic [7:0] trim;
   int mismatches = 0, n_compared = 0, cyc = 0, n_core, n_pm, n_per, n_conv;

   // short counts keep the long time-out and slow start-ups affordable
   clock_source_and_distribution #(.WD_LONG_TICKS(17'h00010), .SU_16K_TICKS(17'h00008),
      .SU_32K_TICKS(17'h0000C)) clock_source_and_distribution_inst (
      .I_REF_CLK(clk), .I_RST_N(rst_n), .I_CLOCK_SOURCE_SELECT_FUSES(cks),
      .I_STARTUP_TIME_FUSES(suf), .I_DIVIDE_BY_EIGHT_FUSE(dv), .I_WATCHDOG_OSC_TICK(wdo),
      .I_SRC_OSC_TICK(srct), .I_ASYNC_SRC_LEVEL(asy), .I_CAL_BYTE(cal), .I_SLEEP_REQ(sreq),
      .I_SLEEP_MODE(smode), .I_WAKE(wake), .O_CORE_CLOCK(core_c),
      .O_PROGRAM_MEMORY_CLOCK(pm_c), .O_PERIPHERAL_CLOCK(per_c), .O_CONVERTER_CLOCK(conv_c),
      .O_ASYNC_TIMER_CLOCK(asy_c), .O_SRC_ENABLE(src), .O_CFG_INVALID(inv),
      .O_CORE_HALTED(halted), .O_INSTR_EN(instr), .O_ASYNC_INT_DETECT(det),
      .O_SERIAL_START_ASYNC(ser), .O_DIV8_ACTIVE(div8), .O_OSC_TRIM(trim));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // gated clocks are counted on their own edges
   always @(posedge core_c) n_core++;
   always @(posedge pm_c) n_pm++;
   always @(posedge per_c) n_per++;
   always @(posedge conv_c) n_conv++;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         end_sim();
      end
   end

   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clk);
   endtask

   // w selects watchdog ticks, else source ticks; each tick is one cycle
   task automatic ticks(input bit w, input int n);
      for (int i = 0; i < n; i++) begin
         @(negedge clk);
         {wdo, srct} = w ? 2'h2 : 2'h1;
      end
      @(negedge clk);
      {wdo, srct} = 2'h0;
   endtask

   task automatic count(input int n);
      @(negedge clk);
      n_core = 0;
      n_pm = 0;
      n_per = 0;
      n_conv = 0;
      cycles(n);
   endtask

   task automatic wait_run;
      for (int i = 0; i < 6 && instr !== 1'b1; i++) @(negedge clk);
      chk(instr, 1);
   endtask

   task automatic boot(input logic [3:0] c, input logic [1:0] s, input logic d, input int su,
                       input int wd);
      @(negedge clk);
      {cks, suf, dv, rst_n} = {c, s, d, 1'b0};
      cycles(6);
      chk(trim, cal);
      chk(div8, !d);
      chk(halted, 1);
      rst_n = 1'b1;
      ticks(0, su - 1);
      cycles(2);
      chk(instr, 0);
      ticks(0, 1);
      if (wd > 0) begin
         cycles(2);
         ticks(1, wd - 1);
         cycles(2);
         chk(instr, 0);
         ticks(1, 1);
      end
      wait_run();
   endtask

   task automatic t_boot;
      boot(4'h2, 2'h2, 1'b0, 6, 16);
      chk(src, 4'h2);
      chk(div8, 1);
      count(64);
      chk(n_core, 8);
      chk(n_pm, 8);
      cal = 8'h3C;
      boot(4'h2, 2'h1, 1'b1, 6, 4096);
      chk(div8, 0);
      boot(4'hF, 2'h3, 1'b1, 8, 16);
      boot(4'h5, 2'h0, 1'b1, 12, 0);
      $display("test boot done");
   endtask

   task automatic t_decode;
      for (int c = 0; c < 16; c++) begin
         cks = c[3:0];
         cycles(2);
         chk(src, c > 7 ? 4'h8 : c > 3 ? 4'h4 : c == 2 ? 4'h2 : c == 0 ? 4'h1 : 4'h0);
         chk(inv, c == 1 || c == 3);
      end
      rst_n = 1'b0;
      cks = 4'h3;
      cycles(6);
      rst_n = 1'b1;
      asy = 1'b1;
      ticks(0, 20);
      chk(halted, 1);
      chk(asy_c, 0);
      asy = 1'b0;
      $display("test decode done");
   endtask

   task automatic sleep_case(input sleep_mode_t m, input logic p, input logic v, input logic a,
                             input logic deep);
      @(negedge clk);
      {smode, sreq} = {m, 1'b1};
      @(negedge clk);
      sreq = 1'b0;
      cycles(2);
      chk(halted, 1);
      chk(det, !p);
      chk(ser, !p);
      count(16);
      chk(n_core + n_pm, 0);
      chk(n_per, p ? 16 : 0);
      chk(n_conv, v ? 16 : 0);
      asy = 1'b1;
      cycles(2);
      chk(asy_c, a);
      asy = 1'b0;
      @(negedge clk);
      wake = 1'b1;
      @(negedge clk);
      wake = 1'b0;
      if (deep) begin
         ticks(0, 5);
         cycles(2);
         chk(instr, 0);
         ticks(0, 1);
      end
      wait_run();
   endtask

   task automatic t_sleep;
      boot(4'h2, 2'h0, 1'b1, 6, 0);
      count(16);
      chk(n_core + n_per + n_conv, 48);
      chk(det, 0);
      sleep_case(SLP_IDLE, 1, 1, 1, 0);
      sleep_case(SLP_CONV_NOISE_RED, 0, 1, 1, 0);
      sleep_case(SLP_POWER_DOWN, 0, 0, 0, 1);
      sleep_case(SLP_POWER_SAVE, 0, 0, 1, 1);
      sleep_case(SLP_STANDBY, 0, 0, 1, 0);
      $display("test sleep done");
   endtask

   initial begin
      {rst_n, dv, wdo, srct, asy, sreq, wake} = 7'h00;
      {cks, suf, cal, smode} = {4'h2, 2'h2, 8'hA5, SLP_IDLE};
      t_boot();
      t_decode();
      t_sleep();
      end_sim();
   end
endmodule // clock_source_and_distribution_bench
